/* File: hw/lmcd_regs.svh */
// Register offsets, field positions, codes and reset values of the decoder
`ifndef LMCD_REGS_SVH
`define LMCD_REGS_SVH
`define LMCD_CFG_OFS     8'h00
`define LMCD_STAT_OFS    8'h04
`define LMCD_PAR0_OFS    8'h08
`define LMCD_PAR1_OFS    8'h0c
`define LMCD_NODE_LSB    0
`define LMCD_DIRID_LSB   8
`define LMCD_GP4ID_LSB   16
`define LMCD_PTR_LSB     24
`define LMCD_NODE_RST    7'h00
`define LMCD_DIRID_RST   6'h00
`define LMCD_GP4ID_RST   6'h20
`define LMCD_PTR_RST     4'h1
`define LMCD_PTR_GP4     4'h1
`define LMCD_GP4_TAG     2'h2
`define LMCD_MREQ_ID     6'h3c
`define LMCD_MREQ_LEN    4'h8
`define LMCD_DIRECT_LEN  4'h2
`define LMCD_GP4_LEN     4'h4
`define LMCD_APP_CODE    8'h80
`define LMCD_CODE_DUAL   7'h08
`define LMCD_CODE_PARAM  7'h09
`define LMCD_CODE_MOVE   7'h0b
`define LMCD_CODE_FUSE   7'h10
`define LMCD_FUSE_PAD    5'h1f
`define LMCD_FILL        8'hff
`endif

/* File: hw/lmcd_pkg.sv */
// Types shared by the motion command decoder
package lmcd_pkg;
  typedef struct packed {
    logic [7:0]  pid;
    logic [3:0]  len;
    logic [63:0] data;
    logic [7:0]  csum;
  } lmcd_frame_t;
  typedef struct packed {
    logic [3:0]  run_cur;
    logic [3:0]  hold_cur;
    logic [3:0]  top_speed;
    logic [3:0]  bottom_speed;
    logic [10:0] safe_position;
    logic        direction;
    logic [3:0]  ramp_rate;
    logic        ramp_profile_select;
    logic [1:0]  stepping_resolution;
  } lmcd_param_t;
  typedef struct packed {
    logic [3:0]  vmax;
    logic [3:0]  vmin;
    logic [15:0] first_target;
    logic [15:0] second_target;
  } lmcd_dual_t;
  typedef enum logic [2:0] {
    LMCD_NONE, LMCD_MOVE, LMCD_DUAL, LMCD_PARAM, LMCD_FUSE
  } lmcd_cmd_t;
endpackage

/* File: hw/lmcd_decoder.sv */
// LIN motion and configuration command decoder with Wishbone registers
// What this block does
// - Dual move frame with broadcast bit 0 runs on every node.
// - Dual move: one nibble first-move top speed, other bottom/second speed.
// - Dual move goes to 16-bit first target, then second target.
// - Motor parameter frame loads all nine settings into RAM copies.
// - New motion parameters take effect at once, even mid-move.
// - Parameter frame: id 0x3C, eight bytes, app code, code 0x09, address.
// - Parameter frame byte layout of currents, speeds, safe position, etc.
// - Parameter frame with broadcast bit 0 loads on every node.
// - Fuse write programs data into 3-bit addressed byte, then fuses it.
// - Fuse frame: code 0x10, pad ones, address, data, three 0xff bytes.
// - Fuse frame with broadcast bit 0 programs every node.
// - Absolute move drives motor to target; one frame serves two motors.
// - Absolute move dropped when priority logic refuses it.
// - Direct form: two bytes, id bit 5 clear, target high byte first.
// - General form: four bytes, id bits 5:4 = 10, code 0x0B, address.
// - General four-byte form is bound to decoder pointer 0001.
// - General form with broadcast bit 0 moves every node.
// - Every 16-bit target is signed two's complement; dual_o carries its two targets as unsigned logic [15:0].
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "lmcd_regs.svh"
module lmcd_decoder (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [7:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output logic      [31:0]          wb_dat_o,
  output logic                      wb_ack_o,
  input  wire logic                 frame_valid_i,
  input  wire lmcd_pkg::lmcd_frame_t frame_i,
  input  wire logic                 pos_accept_i,
  output logic                      move_valid_o,
  output logic signed [15:0]        move_target_o,
  output logic                      dual_valid_o,
  output lmcd_pkg::lmcd_dual_t      dual_o,
  output lmcd_pkg::lmcd_param_t     param_o,
  output logic                      fuse_prog_o,
  output logic                      fuse_zap_o,
  output logic      [2:0]           fuse_addr_o,
  output logic      [7:0]           fuse_data_o
);

  function automatic logic pid_ok_f(input logic [7:0] p);
    logic p0;
    logic p1;
    p0 = p[0] ^ p[1] ^ p[2] ^ p[4];
    p1 = ~(p[1] ^ p[3] ^ p[4] ^ p[5]);
    return p[7:6] == {p1, p0};
  endfunction

  // Classic sum with carry fold over the data bytes only
  function automatic logic [7:0] csum_f(input logic [63:0] d,
                                        input logic [3:0] n);
    logic [7:0] acc;
    logic [8:0] s;
    acc = 8'h00;
    for (int i = 0; i < 8; i++) begin
      if (4'(i) < n) begin
        s = {1'b0, acc} + {1'b0, d[8*i +: 8]};
        acc = s[7:0] + {7'h00, s[8]};
      end
    end
    return ~acc;
  endfunction

  function automatic logic hit_f(input logic [7:0] ab,
                                 input logic [6:0] node);
    return !ab[7] || ab[6:0] == node;
  endfunction

  logic [6:0] node_q;
  logic [5:0] dirid_q;
  logic [5:0] gp4id_q;
  logic [3:0] ptr_q;
  logic [7:0] acc_cnt_q;
  logic [7:0] rej_cnt_q;
  logic [2:0] last_q;

  logic [7:0]            b [8];
  logic [5:0]            id6;
  logic                  frame_ok;
  logic                  mreq;
  logic [6:0]            code;
  logic                  move_go;
  logic                  dual_go;
  logic                  par_go;
  logic                  fuse_go;
  logic [15:0]           tgt;
  lmcd_pkg::lmcd_param_t par_w;
  lmcd_pkg::lmcd_cmd_t   kind;

  always_comb begin
    for (int k = 0; k < 8; k++) begin
      b[k] = frame_i.data[8*k +: 8];
    end
  end

  assign id6 = frame_i.pid[5:0];
  assign code = b[1][6:0];
  assign frame_ok = frame_valid_i && pid_ok_f(frame_i.pid) &&
                    frame_i.len <= `LMCD_MREQ_LEN &&
                    csum_f(frame_i.data, frame_i.len) == frame_i.csum;
  assign mreq = id6 == `LMCD_MREQ_ID && frame_i.len == `LMCD_MREQ_LEN &&
                b[0] == `LMCD_APP_CODE && b[1][7];

  // Unpack the parameter layout
  assign par_w = '{run_cur:             b[3][7:4],
                   hold_cur:            b[3][3:0],
                   top_speed:           b[4][7:4],
                   bottom_speed:        b[4][3:0],
                   safe_position:       {b[5][7:5], b[6]},
                   direction:           b[5][4],
                   ramp_rate:           b[5][3:0],
                   ramp_profile_select: b[7][4],
                   stepping_resolution: b[7][3:2]};

  assign dual_go = frame_ok && mreq && code == `LMCD_CODE_DUAL &&
                   hit_f(b[2], node_q);
  assign par_go = frame_ok && mreq && code == `LMCD_CODE_PARAM &&
                  hit_f(b[2], node_q);
  assign fuse_go = frame_ok && mreq && code == `LMCD_CODE_FUSE &&
                   hit_f(b[2], node_q) && b[3][7:3] == `LMCD_FUSE_PAD &&
                   b[5] == `LMCD_FILL && b[6] == `LMCD_FILL &&
                   b[7] == `LMCD_FILL;

  // Absolute move forms: direct, general four-byte, two-motor request
  always_comb begin
    move_go = 1'b0;
    tgt = 16'h0000;
    if (id6 == dirid_q && !id6[5] &&
        frame_i.len == `LMCD_DIRECT_LEN) begin
      move_go = 1'b1;
      tgt = {b[0], b[1]};
    end else if (ptr_q == `LMCD_PTR_GP4 && id6 == gp4id_q &&
                 id6[5:4] == `LMCD_GP4_TAG &&
                 frame_i.len == `LMCD_GP4_LEN &&
                 b[0] == {1'b1, `LMCD_CODE_MOVE} &&
                 hit_f(b[1], node_q)) begin
      move_go = 1'b1;
      tgt = {b[2], b[3]};
    end else if (mreq && code == `LMCD_CODE_MOVE) begin
      if (b[2] == {1'b1, node_q}) begin
        move_go = 1'b1;
        tgt = {b[3], b[4]};
      end else if (b[5] == {1'b1, node_q}) begin
        move_go = 1'b1;
        tgt = {b[6], b[7]};
      end
    end
    move_go = move_go && frame_ok && pos_accept_i;
  end

  always_comb begin
    kind = lmcd_pkg::LMCD_NONE;
    case (1'b1)
      move_go: kind = lmcd_pkg::LMCD_MOVE;
      dual_go: kind = lmcd_pkg::LMCD_DUAL;
      par_go:  kind = lmcd_pkg::LMCD_PARAM;
      fuse_go: kind = lmcd_pkg::LMCD_FUSE;
      default: kind = lmcd_pkg::LMCD_NONE;
    endcase
  end

  // Absolute move strobe; target kept signed for the position loop
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      move_valid_o <= 1'b0;
      move_target_o <= 16'sh0000;
    end else begin
      move_valid_o <= move_go;
      if (move_go) begin
        move_target_o <= signed'(tgt);
      end
    end
  end

  // Dual move strobe with speeds and two targets
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dual_valid_o <= 1'b0;
      dual_o <= '0;
    end else begin
      dual_valid_o <= dual_go;
      if (dual_go) begin
        dual_o <= '{vmax: b[3][7:4], vmin: b[3][3:0],
                    first_target: {b[4], b[5]},
                    second_target: {b[6], b[7]}};
      end
    end
  end

  // Drives the controller directly, so a running move sees it at once
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      param_o <= '0;
    end else if (par_go) begin
      param_o <= par_w;
    end
  end

  // Program first, then zap the same byte on the next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fuse_prog_o <= 1'b0;
      fuse_zap_o <= 1'b0;
      fuse_addr_o <= 3'h0;
      fuse_data_o <= 8'h00;
    end else begin
      fuse_prog_o <= fuse_go;
      fuse_zap_o <= fuse_prog_o;
      if (fuse_go) begin
        fuse_addr_o <= b[3][2:0];
        fuse_data_o <= b[4];
      end
    end
  end

  // Counters wrap; software takes differences
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_cnt_q <= 8'h00;
      rej_cnt_q <= 8'h00;
      last_q <= 3'h0;
    end else if (frame_valid_i) begin
      if (!frame_ok) begin
        rej_cnt_q <= rej_cnt_q + 8'h01;
      end else if (kind != lmcd_pkg::LMCD_NONE) begin
        acc_cnt_q <= acc_cnt_q + 8'h01;
        last_q <= kind;
      end
    end
  end

  logic wb_req;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      node_q <= `LMCD_NODE_RST;
      dirid_q <= `LMCD_DIRID_RST;
      gp4id_q <= `LMCD_GP4ID_RST;
      ptr_q <= `LMCD_PTR_RST;
    end else if (wb_req && wb_we_i && wb_adr_i == `LMCD_CFG_OFS) begin
      if (wb_sel_i[0]) begin
        node_q <= wb_dat_i[`LMCD_NODE_LSB +: 7];
      end
      if (wb_sel_i[1]) begin
        dirid_q <= wb_dat_i[`LMCD_DIRID_LSB +: 6];
      end
      if (wb_sel_i[2]) begin
        gp4id_q <= wb_dat_i[`LMCD_GP4ID_LSB +: 6];
      end
      if (wb_sel_i[3]) begin
        ptr_q <= wb_dat_i[`LMCD_PTR_LSB +: 4];
      end
    end
  end

  // One wait state; unmapped addresses answer with zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0000_0000;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `LMCD_CFG_OFS:
            wb_dat_o <= {4'h0, ptr_q, 2'h0, gp4id_q, 2'h0, dirid_q,
                         1'b0, node_q};
          `LMCD_STAT_OFS:
            wb_dat_o <= {13'h0000, last_q, rej_cnt_q, acc_cnt_q};
          `LMCD_PAR0_OFS:
            wb_dat_o <= {16'h0000, param_o.run_cur, param_o.hold_cur,
                         param_o.top_speed, param_o.bottom_speed};
          `LMCD_PAR1_OFS:
            wb_dat_o <= {8'h00, 3'h0, param_o.ramp_profile_select,
                         param_o.stepping_resolution, 2'h0,
                         5'h00, param_o.safe_position};
          default:
            wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  chk_bad_frame_quiet: assert property (
    frame_valid_i && !frame_ok |=> !move_valid_o && !dual_valid_o &&
      !fuse_prog_o && $stable(param_o))
    else $error("bad frame produced an action");
  chk_dual_broadcast: assert property (
    frame_ok && mreq && code == `LMCD_CODE_DUAL && !b[2][7]
      |=> dual_valid_o)
    else $error("broadcast dual move not taken");
  chk_dual_fields: assert property (
    dual_go |=> dual_o.second_target == $past({b[6], b[7]}) &&
      dual_o.vmin == $past(b[3][3:0]))
    else $error("dual move fields wrong");
  chk_param_load: assert property (
    par_go |=> param_o == $past(par_w) ##1
      ($stable(param_o) || $past(par_go)))
    else $error("parameters not loaded");
  chk_fuse_sequence: assert property (
    fuse_go && !fuse_prog_o |=> fuse_prog_o && !fuse_zap_o ##1
      fuse_zap_o && ($stable(fuse_addr_o) || $past(fuse_go)))
    else $error("fuse program then zap order broken");
  chk_move_refused: assert property (
    frame_valid_i && !pos_accept_i |=> !move_valid_o)
    else $error("refused move was issued");
  chk_addr_filter: assert property (
    frame_valid_i && mreq && b[2][7] && b[2][6:0] != node_q &&
      code != `LMCD_CODE_MOVE
      |=> !dual_valid_o && !fuse_prog_o && $stable(param_o))
    else $error("foreign address acted upon");
  chk_direct_target: assert property (
    move_go && !id6[5] |=> move_valid_o &&
      move_target_o == $past({b[0], b[1]}))
    else $error("direct move target wrong");
  chk_wb_single_ack: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
endmodule

/* File: verification/lmcd_lin_master.sv */
// Behavioural LIN master handing finished frames to the decoder
`timescale 1ns/1ps
module lmcd_lin_master (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              send_i,
  input  wire logic [5:0]        id_i,
  input  wire logic [3:0]        len_i,
  input  wire logic [63:0]       data_i,
  input  wire logic [1:0]        fault_i,
  output logic                   frame_valid_o,
  output lmcd_pkg::lmcd_frame_t  frame_o
);
  logic [7:0] pid;

  // Classic sum over data bytes only, carry folded back in
  function automatic logic [7:0] csum(input logic [63:0] d,
                                      input logic [3:0]  n);
    logic [8:0] s;
    s = 9'h000;
    for (int k = 0; k < 8; k++) begin
      if (k < n) begin
        s = s + {1'b0, d[8*k +: 8]};
        if (s[8]) s = s - 9'h0ff;
      end
    end
    return ~s[7:0];
  endfunction

  // Fault bit 1 spoils the low parity bit on purpose
  assign pid = {~(id_i[1] ^ id_i[3] ^ id_i[4] ^ id_i[5]),
                id_i[0] ^ id_i[1] ^ id_i[2] ^ id_i[4] ^ fault_i[1],
                id_i};

  always_ff @(posedge clk_i) begin
    frame_valid_o <= send_i && !rst_i;
    if (rst_i) begin
      frame_o <= '0;
    end else if (send_i) begin
      frame_o <= {pid, len_i, data_i,
                  csum(data_i, len_i) ^ {7'h00, fault_i[0]}};
    end else begin
      // Idle lines keep changing so stale data is never mistaken
      frame_o <= ~frame_o;
    end
  end
endmodule

/* File: verification/tb_lmcd_decoder.sv */
// Self-checking bench for the motion command decoder
`timescale 1ns/1ps
module tb_lmcd_decoder;
  logic                  clk_i = 1'b0;
  logic                  rst_i = 1'b1;
  logic                  wb_cyc_i = 1'b0;
  logic                  wb_stb_i = 1'b0;
  logic                  wb_we_i = 1'b0;
  logic [7:0]            wb_adr_i = 8'h00;
  logic [3:0]            wb_sel_i = 4'hf;
  logic [31:0]           wb_dat_i = 32'h0;
  logic [31:0]           wb_dat_o;
  logic                  wb_ack_o;
  logic                  frame_valid_i;
  lmcd_pkg::lmcd_frame_t frame_i;
  logic                  pos_accept_i = 1'b1;
  logic                  move_valid_o;
  logic signed [15:0]    move_target_o;
  logic                  dual_valid_o;
  lmcd_pkg::lmcd_dual_t  dual_o;
  lmcd_pkg::lmcd_param_t param_o;
  logic                  fuse_prog_o;
  logic                  fuse_zap_o;
  logic [2:0]            fuse_addr_o;
  logic [7:0]            fuse_data_o;
  logic                  send_i = 1'b0;
  logic [5:0]            id_i = 6'h00;
  logic [3:0]            len_i = 4'h0;
  logic [63:0]           data_i = 64'h0;
  logic [1:0]            fault_i = 2'h0;
  logic [31:0]           seed = 32'h18d2;
  logic [39:0]           r;
  logic [7:0]            adr;
  logic                  prog_q = 1'b0;
  logic [66:0]           notes[$];
  int                    mismatches = 0;
  int                    checked = 0;
  int                    cycles = 0;

  lmcd_decoder lmcd_decoder_inst (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .frame_valid_i, .frame_i, .pos_accept_i, .move_valid_o, .move_target_o,
    .dual_valid_o, .dual_o, .param_o, .fuse_prog_o, .fuse_zap_o,
    .fuse_addr_o, .fuse_data_o);
  lmcd_lin_master lmcd_lin_master_inst (.clk_i, .rst_i, .send_i, .id_i,
    .len_i, .data_i, .fault_i, .frame_valid_o(frame_valid_i),
    .frame_o(frame_i));

  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr_f(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic roll();
    repeat (32) seed = lfsr_f(seed);
  endtask

  task automatic chk(input logic [63:0] seen, exp, input string what);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic note(input logic [2:0] k, input logic [63:0] v);
    notes.push_back({k, v});
  endtask

  task automatic take(input logic [2:0] k, input logic [63:0] v);
    logic [66:0] n;
    if (notes.size() == 0) begin
      mismatches++;
      $display("wrong value output %0d expected none seen %h", k, v);
    end else begin
      n = notes.pop_front();
      chk({61'h0, k}, {61'h0, n[66:64]}, "result kind");
      chk(v, n[63:0], "result value");
    end
  endtask

  task automatic stop_test();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Request held until ack is sampled, then one idle cycle follows
  task automatic wb_cycle(input logic we, input logic [7:0] a,
                          input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  task automatic wb_read(input logic [7:0] a, input logic [31:0] exp);
    note(3'd5, {32'h0, exp});
    wb_cycle(1'b0, a, 32'h0, 4'hf);
  endtask

  task automatic send(input logic [5:0] id, input logic [3:0] n,
                      input logic [63:0] d, input logic [1:0] f);
    @(posedge clk_i);
    send_i  <= 1'b1;
    id_i    <= id;
    len_i   <= n;
    data_i  <= d;
    fault_i <= f;
    @(posedge clk_i);
    send_i <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask

  always @(posedge clk_i) begin
    if (!rst_i) begin
      if (move_valid_o) take(3'd1, {48'h0, move_target_o});
      if (dual_valid_o) take(3'd2, {24'h0, dual_o});
      if (fuse_prog_o) take(3'd4, {53'h0, fuse_addr_o, fuse_data_o});
      if (prog_q) chk({63'h0, fuse_zap_o}, 64'h1, "fuse zap");
      if (wb_ack_o && !wb_we_i) take(3'd5, {32'h0, wb_dat_o});
    end
    prog_q <= fuse_prog_o && !rst_i;
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wb_read(8'h00, 32'h01200000);
    wb_cycle(1'b1, 8'h04, 32'hffffffff, 4'hf);
    wb_read(8'h04, 32'h0);
    wb_read(8'h10, 32'h0);
    wb_cycle(1'b1, 8'h00, 32'h01210a15, 4'hf);
    wb_cycle(1'b1, 8'h00, 32'h00000033, 4'h1);
    wb_read(8'h00, 32'h01210a33);
    $display("test registers done");
    for (int i = 0; i < 4; i++) begin
      roll();
      pos_accept_i <= (i != 1);
      if (i == 0) note(3'd1, {48'h0, seed[15:0]});
      send(6'h0a, 4'h2, {48'h0, seed[7:0], seed[15:8]}, {i == 3, i == 2});
    end
    pos_accept_i <= 1'b1;
    $display("test direct move done");
    for (int j = 0; j < 3; j++) begin
      roll();
      adr = (j == 0) ? 8'hb3 : {j[1], 7'h12};
      if (j < 2) note(3'd1, {48'h0, seed[15:0]});
      send(6'h21, 4'h4, {32'h0, seed[7:0], seed[15:8], adr, 8'h8b}, 2'h0);
    end
    wb_cycle(1'b1, 8'h00, 32'h0, 4'h8);
    send(6'h21, 4'h4, {32'h0, 16'h1234, 8'hb3, 8'h8b}, 2'h0);
    wb_cycle(1'b1, 8'h00, 32'h01000000, 4'h8);
    // Two-motor request: first slot foreign, second slot ours
    roll();
    note(3'd1, {48'h0, seed[15:0]});
    send(6'h3c, 4'h8, {seed[7:0], seed[15:8], 48'hb30000928b80}, 2'h0);
    $display("test general move done");
    roll();
    r[31:0] = seed;
    roll();
    r[39:32] = seed[7:0];
    note(3'd2, {24'h0, r});
    send(6'h3c, 4'h8, {r[7:0], r[15:8], r[23:16], r[31:24], r[39:32],
                       8'h12, 8'h88, 8'h80}, 2'h0);
    roll();
    r[31:0] = seed;
    // Every field loads at once here, as it would with a move running
    send(6'h3c, 4'h8, {r[7:0], r[15:8], r[23:16], r[31:24], r[39:32],
                       8'h12, 8'h89, 8'h80}, 2'h0);
    send(6'h3c, 4'h8, {~{r[7:0], r[15:8], r[23:16], r[31:24], r[39:32]},
                       8'h92, 8'h89, 8'h80}, 2'h0);
    chk(param_o, {r[39:24], r[23:21], r[15:8], r[20], r[19:16], r[4],
                  r[3:2]}, "param");
    wb_read(8'h08, {16'h0, r[39:24]});
    wb_read(8'h0c, {11'h0, r[4], r[3:2], 7'h0, r[23:21], r[15:8]});
    $display("test dual and param done");
    for (int a = 0; a < 8; a++) begin
      roll();
      note(3'd4, {53'h0, a[2:0], seed[7:0]});
      send(6'h3c, 4'h8, {24'hffffff, seed[7:0], 5'h1f, a[2:0], 8'h12,
                         8'h90, 8'h80}, 2'h0);
    end
    send(6'h3c, 4'h8, {24'hfeffff, 8'h5a, 8'hf9, 8'h12, 8'h90, 8'h80},
         2'h0);
    wb_read(8'h04, 32'h0004020e);
    repeat (4) @(posedge clk_i);
    chk(64'(notes.size()), 64'h0, "pending results");
    $display("test fuse and status done");
    stop_test();
  end
endmodule
